// file: hw/ics_defines.svh
// Constants of the I/O channel configuration and surveillance block.
// Assumes it is included by the package and the design modules by bare name.
`ifndef ICS_DEFINES_SVH
`define ICS_DEFINES_SVH

// Object indexes of the configuration port
`define ICS_IDX_GEN 16'h2381
`define ICS_IDX_DLY 16'h2382
`define ICS_IDX_DIR 16'h2383
`define ICS_IDX_POL 16'h2384
`define ICS_IDX_FILT 16'h2385

// Entry counts, read back at subindex zero
`define ICS_CNT_GEN 8'h07
`define ICS_CNT_CH 8'h10
`define ICS_CNT_PORT 8'h08

// Bit positions inside the general settings (subindex minus one)
`define ICS_GEN_WEB 3'h0
`define ICS_GEN_FORCE 3'h1
`define ICS_GEN_ALL 3'h2
`define ICS_GEN_AUX 3'h3
`define ICS_GEN_ACT 3'h4
`define ICS_GEN_EXT 3'h5
`define ICS_GEN_RESTART 3'h6

// Field codes and reset values
`define ICS_BOOL_MAX 8'h01
`define ICS_DIR_IN 8'h01
`define ICS_DIR_OUT 8'h02
`define ICS_POL_NC 8'h01
`define ICS_DLY_DEFAULT_MS 8'h50
`define ICS_DLY_STATIC_MS 8'h64

// Emergency classes
`define ICS_EMCY_GEN 2'h0
`define ICS_EMCY_AUX 2'h1
`define ICS_EMCY_ACT 2'h2

// Millisecond time base
`define ICS_MS_NS 32'h000f4240
`define ICS_CLK_NS 32'h00000019

`endif

// file: hw/ics_pkg.sv
// Types of the I/O channel configuration and surveillance block.
// Assumes ics_defines.svh is on the include path.
`include "ics_defines.svh"

package ics_pkg;

  typedef enum logic {ICS_ST_SETTLE, ICS_ST_WATCH} ics_chan_st_t;

  typedef struct packed {
    ics_chan_st_t st;
    logic [7:0] cnt;
    logic prev_cmd;
    logic mon;
    logic shut;
    logic drive;
    logic raw;
    logic [7:0] fcnt;
    logic di;
  } ics_chan_state_t;

  typedef struct packed {
    logic [15:0] tcnt;
    logic tick;
    logic [7:0] gen;
    logic [15:0][7:0] dly;
    logic [7:0][7:0] dir;
    logic [15:0] pol;
    logic [15:0][7:0] filt;
    logic [7:0] chb_out;
    logic ack;
    logic err;
    logic [7:0] rdata;
    logic emcy;
  } ics_top_state_t;

endpackage

// file: hw/ics_chan.sv
// One channel: surveillance delay, fault shutdown, input filter and polarity.
// Assumes a one-cycle millisecond tick and inputs synchronous to core_clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "ics_defines.svh"

module ics_chan
  import ics_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic out_cmd_i,
  input wire logic fault_i,
  input wire logic di_mode_i,
  input wire logic pol_nc_i,
  input wire logic [7:0] filt_i,
  input wire logic [7:0] delay_i,
  input wire logic restart_en_i,
  input wire logic pin_i,
  output logic monitor_o,
  output logic drive_o,
  output logic di_o
);

  ics_chan_state_t s_reg;
  ics_chan_state_t s_next;
  logic edge_seen;

  always_comb begin
    s_next = s_reg;
    edge_seen = out_cmd_i != s_reg.prev_cmd;
    s_next.prev_cmd = out_cmd_i;
    if (edge_seen) begin
      s_next.st = ICS_ST_SETTLE; // R1
      s_next.cnt = delay_i; // R3
    end else if (s_reg.st == ICS_ST_SETTLE) begin
      if (s_reg.cnt == 8'h00) begin
        s_next.st = ICS_ST_WATCH; // R2
      end else if (tick_i) begin
        s_next.cnt = s_reg.cnt - 8'h01;
      end
    end
    s_next.mon = s_next.st == ICS_ST_WATCH;
    // Faults count only once the delay has run out
    if (s_reg.mon && fault_i) begin
      s_next.shut = 1'b1; // R2
    end else if (s_reg.shut && !fault_i && (restart_en_i || !out_cmd_i)) begin
      s_next.shut = 1'b0; // R13
    end
    s_next.drive = out_cmd_i && !s_next.shut;
    if (!di_mode_i || filt_i == 8'h00 || pin_i == s_reg.raw) begin
      s_next.raw = pin_i; // R8
      s_next.fcnt = 8'h00;
    end else if (tick_i) begin
      if (s_reg.fcnt + 8'h01 >= filt_i) begin
        s_next.raw = pin_i; // R9
        s_next.fcnt = 8'h00;
      end else begin
        s_next.fcnt = s_reg.fcnt + 8'h01;
      end
    end
    s_next.di = di_mode_i ? (s_next.raw ^ pol_nc_i) : pin_i; // R12
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.cnt <= `ICS_DLY_STATIC_MS; // R4
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign monitor_o = s_reg.mon;
  assign drive_o = s_reg.drive;
  assign di_o = s_reg.di;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence zero_edge_s;
    ce_i && edge_seen && delay_i == 8'h00;
  endsequence
  sequence quiet_s;
    ce_i && !edge_seen;
  endsequence

  edge_settle_a: assert property (ce_i && edge_seen |=> !monitor_o) // R1
    else $error("monitoring active right after an output edge");
  zero_expire_a: assert property (zero_edge_s ##1 quiet_s |=> monitor_o) // R2
    else $error("zero delay did not start monitoring");
  no_early_shut_a: assert property (ce_i && !s_reg.mon && !s_reg.shut |=> !s_reg.shut) // R2
    else $error("shutdown before surveillance delay expired");
  restart_a: assert property (ce_i && s_reg.shut && !fault_i && restart_en_i |=> !s_reg.shut) // R13
    else $error("automatic restart did not clear shutdown");
  nc_invert_a: assert property (ce_i && di_mode_i && filt_i == 8'h00 |=> di_o == ($past(pin_i) ^ $past(pol_nc_i))) // R12
    else $error("normally closed input not inverted");
  mode_ignore_a: assert property (ce_i && !di_mode_i |=> di_o == $past(pin_i)) // R8
    else $error("polarity or filter applied outside input mode");

endmodule // ics_chan
`default_nettype wire

// file: hw/ics_top.sv
// Channel configuration objects and per-channel surveillance for eight ports.
// Assumes the configuration port and all pins are synchronous to core_clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "ics_defines.svh"

// Overview of operation
// [R1] Output edge restarts channel surveillance delay
// [R2] Current faults count only after delay expires
// [R3] Delay 0 to 255 ms, default 80
// [R4] Static output uses 100 ms value
// [R5] Sixteen independent 8-bit surveillance delays
// [R6] Channel B direction: 1 input, 2 output
// [R7] Polarity 0 normally open, 1 closed
// [R8] Polarity and filter only in input mode
// [R9] Sixteen independent 8-bit input filter settings
// [R10] Seven boolean general settings, 0 or 1
// [R11] Disable-all setting suppresses every emergency message
// [R12] Normally closed inverts the sampled pin
// [R13] Auto restart re-enables output after fault
module ics_top
  import ics_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `ICS_MS_NS / `ICS_CLK_NS
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sdo_wr_i,
  input wire logic sdo_rd_i,
  input wire logic [15:0] sdo_index_i,
  input wire logic [7:0] sdo_sub_i,
  input wire logic [7:0] sdo_wdata_i,
  output logic sdo_ack_o,
  output logic sdo_err_o,
  output logic [7:0] sdo_rdata_o,
  input wire logic [15:0] out_cmd_i,
  input wire logic [15:0] fault_i,
  input wire logic [7:0] port_di_mode_i,
  input wire logic [15:0] pin_i,
  input wire logic emcy_req_i,
  input wire logic [1:0] emcy_class_i,
  output logic emcy_send_o,
  output logic [15:0] out_drive_o,
  output logic [15:0] monitor_en_o,
  output logic [15:0] di_value_o,
  output logic [7:0] chb_out_o,
  output logic web_lock_o,
  output logic force_lock_o,
  output logic ext_cfg_o
);

  ics_top_state_t s_reg;
  ics_top_state_t s_next;
  logic [3:0] ent;
  logic [7:0] cnt;
  logic [7:0] rd;
  logic hit;
  logic suppress;

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.err = 1'b0;
    s_next.emcy = 1'b0;
    s_next.tick = 1'b0;
    if (s_reg.tcnt == 16'(TICK_CYCLES - 1)) begin
      s_next.tcnt = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.tcnt = s_reg.tcnt + 16'h0001;
    end
    ent = 4'(sdo_sub_i - 8'h01);
    hit = 1'b1;
    cnt = 8'h00;
    rd = 8'h00;
    case (sdo_index_i)
      `ICS_IDX_GEN: begin
        cnt = `ICS_CNT_GEN;
        rd = {7'h00, s_reg.gen[ent[2:0]]};
      end
      `ICS_IDX_DLY: begin
        cnt = `ICS_CNT_CH;
        rd = s_reg.dly[ent];
      end
      `ICS_IDX_DIR: begin
        cnt = `ICS_CNT_PORT;
        rd = s_reg.dir[ent[2:0]];
      end
      `ICS_IDX_POL: begin
        cnt = `ICS_CNT_CH;
        rd = {7'h00, s_reg.pol[ent]};
      end
      `ICS_IDX_FILT: begin
        cnt = `ICS_CNT_CH;
        rd = s_reg.filt[ent];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (sdo_rd_i || sdo_wr_i) begin
      s_next.ack = 1'b1;
      if (!hit || sdo_sub_i > cnt) begin
        s_next.err = 1'b1;
      end else if (sdo_rd_i) begin
        s_next.rdata = (sdo_sub_i == 8'h00) ? cnt : rd;
      end else if (sdo_sub_i == 8'h00) begin
        s_next.err = 1'b1;
      end else begin
        case (sdo_index_i)
          `ICS_IDX_GEN: begin
            if (sdo_wdata_i > `ICS_BOOL_MAX) begin
              s_next.err = 1'b1;
            end else begin
              s_next.gen[ent[2:0]] = sdo_wdata_i[0]; // R10
            end
          end
          `ICS_IDX_DLY: begin
            s_next.dly[ent] = sdo_wdata_i; // R3 R5
          end
          `ICS_IDX_DIR: begin
            if (sdo_wdata_i == `ICS_DIR_IN || sdo_wdata_i == `ICS_DIR_OUT) begin
              s_next.dir[ent[2:0]] = sdo_wdata_i; // R6
            end else begin
              s_next.err = 1'b1;
            end
          end
          `ICS_IDX_POL: begin
            if (sdo_wdata_i > `ICS_POL_NC) begin
              s_next.err = 1'b1;
            end else begin
              s_next.pol[ent] = sdo_wdata_i[0]; // R7
            end
          end
          `ICS_IDX_FILT: begin
            s_next.filt[ent] = sdo_wdata_i; // R9
          end
          default: begin
            s_next.err = 1'b1;
          end
        endcase
      end
    end
    for (int p = 0; p < 8; p++) begin
      s_next.chb_out[p] = s_next.dir[p] == `ICS_DIR_OUT; // R6
    end
    suppress = s_reg.gen[`ICS_GEN_ALL] // R11
      || (emcy_class_i == `ICS_EMCY_AUX && s_reg.gen[`ICS_GEN_AUX])
      || (emcy_class_i == `ICS_EMCY_ACT && s_reg.gen[`ICS_GEN_ACT]);
    s_next.emcy = emcy_req_i && !suppress;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.dly <= {16{`ICS_DLY_DEFAULT_MS}}; // R3
      s_reg.dir <= {8{`ICS_DIR_IN}};
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  genvar c;
  generate
    for (c = 0; c < 16; c++) begin : g_chan
      logic is_b;
      logic cmd;
      logic di_mode;
      assign is_b = (c % 2) == 1;
      assign cmd = out_cmd_i[c] && (!is_b || s_reg.chb_out[c / 2]); // R6
      assign di_mode = port_di_mode_i[c / 2] && (!is_b || s_reg.dir[c / 2] == `ICS_DIR_IN); // R8
      ics_chan u_chan (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .tick_i(s_reg.tick),
        .out_cmd_i(cmd),
        .fault_i(fault_i[c]),
        .di_mode_i(di_mode),
        .pol_nc_i(s_reg.pol[c]),
        .filt_i(s_reg.filt[c]),
        .delay_i(s_reg.dly[c]),
        .restart_en_i(s_reg.gen[`ICS_GEN_RESTART]),
        .pin_i(pin_i[c]),
        .monitor_o(monitor_en_o[c]),
        .drive_o(out_drive_o[c]),
        .di_o(di_value_o[c])
      );
    end
  endgenerate

  assign sdo_ack_o = s_reg.ack;
  assign sdo_err_o = s_reg.err;
  assign sdo_rdata_o = s_reg.rdata;
  assign emcy_send_o = s_reg.emcy;
  assign chb_out_o = s_reg.chb_out;
  assign web_lock_o = s_reg.gen[`ICS_GEN_WEB];
  assign force_lock_o = s_reg.gen[`ICS_GEN_FORCE];
  assign ext_cfg_o = s_reg.gen[`ICS_GEN_EXT];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence wr_s(logic [15:0] idx);
    ce_i && sdo_wr_i && !sdo_rd_i && sdo_index_i == idx && sdo_sub_i != 8'h00;
  endsequence

  sdo_ack_a: assert property (ce_i && (sdo_wr_i || sdo_rd_i) |=> sdo_ack_o) // R10
    else $error("configuration access not acknowledged");
  emcy_all_a: assert property (ce_i && emcy_req_i && s_reg.gen[`ICS_GEN_ALL] |=> !emcy_send_o) // R11
    else $error("emergency sent while all are disabled");
  emcy_pass_a: assert property (ce_i && emcy_req_i && emcy_class_i == `ICS_EMCY_GEN
    && !s_reg.gen[`ICS_GEN_ALL] |=> emcy_send_o) // R11
    else $error("enabled emergency was not sent");
  dly_write_a: assert property (wr_s(`ICS_IDX_DLY) && sdo_sub_i <= `ICS_CNT_CH
    |=> s_reg.dly[4'($past(sdo_sub_i) - 8'h01)] == $past(sdo_wdata_i) && !sdo_err_o) // R5
    else $error("surveillance delay write not stored");
  dir_reserved_a: assert property (wr_s(`ICS_IDX_DIR) && sdo_wdata_i != `ICS_DIR_IN
    && sdo_wdata_i != `ICS_DIR_OUT |=> sdo_err_o && $stable(s_reg.dir)) // R6
    else $error("reserved direction code accepted");
  pol_reject_a: assert property (wr_s(`ICS_IDX_POL) && sdo_wdata_i > `ICS_POL_NC |=> sdo_err_o) // R7
    else $error("invalid polarity code accepted");
  filt_write_a: assert property (wr_s(`ICS_IDX_FILT) && sdo_sub_i <= `ICS_CNT_CH
    |=> s_reg.filt[4'($past(sdo_sub_i) - 8'h01)] == $past(sdo_wdata_i)) // R9
    else $error("input filter write not stored");
  gen_reject_a: assert property (wr_s(`ICS_IDX_GEN) && sdo_wdata_i > `ICS_BOOL_MAX |=> sdo_err_o ##1 1'b1) // R10
    else $error("non boolean general setting accepted");
  dly_reset_a: assert property ($fell(reset_i) |-> s_reg.dly[0] == `ICS_DLY_DEFAULT_MS) // R3
    else $error("surveillance delay not at default after reset");

endmodule // ics_top
`default_nettype wire

// file: testbench/ics_sdo_master.sv
// Fieldbus master model writing and reading configuration objects.
// Assumes the answer pulse of ics_top; drives at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module ics_sdo_master (
  input wire logic core_clk_i,
  input wire logic sdo_ack_i,
  input wire logic sdo_err_i,
  input wire logic [7:0] sdo_rdata_i,
  output logic sdo_wr_o,
  output logic sdo_rd_o,
  output logic [15:0] sdo_index_o,
  output logic [7:0] sdo_sub_o,
  output logic [7:0] sdo_wdata_o
);
  logic timed_out = 1'b0;
  initial begin
    sdo_wr_o = 1'b0;
    sdo_rd_o = 1'b0;
    sdo_index_o = 16'h0000;
    sdo_sub_o = 8'h00;
    sdo_wdata_o = 8'h00;
  end
  // One-cycle request, then a bounded wait for the answer
  task automatic xfer(input logic rd, input logic [15:0] ix, input logic [7:0] sb, input logic [7:0] d,
                      output logic e, output logic [7:0] r);
    int n;
    @(negedge core_clk_i);
    sdo_rd_o = rd;
    sdo_wr_o = ~rd;
    sdo_index_o = ix;
    sdo_sub_o = sb;
    sdo_wdata_o = d;
    @(negedge core_clk_i);
    sdo_rd_o = 1'b0;
    sdo_wr_o = 1'b0;
    sdo_wdata_o = ~d;
    n = 0;
    while (sdo_ack_i !== 1'b1 && n < 4) begin
      @(negedge core_clk_i);
      n++;
    end
    if (sdo_ack_i !== 1'b1) timed_out = 1'b1;
    e = sdo_err_i;
    r = sdo_rdata_i;
  endtask
endmodule // ics_sdo_master
`default_nettype wire

// file: testbench/ics_top_bench.sv
// Self-checking bench of ics_top with a short millisecond tick.
// Assumes ics_sdo_master as the configuration partner.
`timescale 1ns/10ps
`default_nettype none
`include "ics_defines.svh"
module ics_top_bench;
  localparam int unsigned TICK = 4;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic sdo_wr, sdo_rd, sdo_ack, sdo_err, emcy_req = 1'b0, emcy_send, web, frc, ext;
  logic [1:0] emcy_cls = 2'h0;
  logic [15:0] sdo_index, out_cmd = 16'h0000, fault = 16'h0000, pin = 16'h0000, drive, mon, di;
  logic [7:0] sdo_sub, sdo_wdata, sdo_rdata, chb, di_mode = 8'h00;
  int fail_count = 0;
  int cmp_count = 0;
  always #12.5 core_clk = ~core_clk;
  ics_top #(.TICK_CYCLES(TICK)) i_ics_top (.core_clk_i(core_clk), .reset_i(reset), .ce_i(ce),
    .sdo_wr_i(sdo_wr), .sdo_rd_i(sdo_rd), .sdo_index_i(sdo_index), .sdo_sub_i(sdo_sub),
    .sdo_wdata_i(sdo_wdata), .sdo_ack_o(sdo_ack), .sdo_err_o(sdo_err), .sdo_rdata_o(sdo_rdata),
    .out_cmd_i(out_cmd), .fault_i(fault), .port_di_mode_i(di_mode), .pin_i(pin), .emcy_req_i(emcy_req),
    .emcy_class_i(emcy_cls), .emcy_send_o(emcy_send), .out_drive_o(drive), .monitor_en_o(mon),
    .di_value_o(di), .chb_out_o(chb), .web_lock_o(web), .force_lock_o(frc), .ext_cfg_o(ext));
  ics_sdo_master i_ics_sdo_master (.core_clk_i(core_clk), .sdo_ack_i(sdo_ack), .sdo_err_i(sdo_err),
    .sdo_rdata_i(sdo_rdata), .sdo_wr_o(sdo_wr), .sdo_rd_o(sdo_rd), .sdo_index_o(sdo_index),
    .sdo_sub_o(sdo_sub), .sdo_wdata_o(sdo_wdata));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic sdo(input logic rd, input logic [15:0] ix, input logic [7:0] sb, input logic [7:0] d,
                     input logic [8:0] x);
    logic e;
    logic [7:0] r;
    i_ics_sdo_master.xfer(rd, ix, sb, d, e, r);
    if (i_ics_sdo_master.timed_out) begin
      fail_count++;
      print_verdict();
    end
    // Bit 8 holds the refusal, the low byte the read data
    chk("sdo answer", {7'h00, x}, {7'h00, e, rd ? r : x[7:0]});
  endtask
  task automatic wait_mon(input int lim, output int n);
    n = 0;
    while (mon[0] !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (mon[0] !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic t_static();
    int n;
    cyc(300);
    chk("monitor before static delay", 16'h0000, mon);
    wait_mon(200, n);
    $display("test static done");
  endtask
  task automatic t_regs();
    sdo(1, `ICS_IDX_GEN, 8'h00, 8'h00, 9'h007);
    sdo(1, `ICS_IDX_DLY, 8'h01, 8'h00, 9'h050);
    sdo(1, `ICS_IDX_DLY, 8'h10, 8'h00, 9'h050);
    sdo(1, `ICS_IDX_DIR, 8'h00, 8'h00, 9'h008);
    sdo(1, `ICS_IDX_POL, 8'h00, 8'h00, 9'h010);
    sdo(1, `ICS_IDX_FILT, 8'h10, 8'h00, 9'h000);
    sdo(0, 16'h2380, 8'h01, 8'h00, 9'h100);
    sdo(0, `ICS_IDX_GEN, 8'h08, 8'h00, 9'h100);
    sdo(0, `ICS_IDX_GEN, 8'h00, 8'h01, 9'h100);
    sdo(0, `ICS_IDX_GEN, 8'h01, 8'h02, 9'h100);
    sdo(0, `ICS_IDX_DIR, 8'h01, 8'h03, 9'h100);
    sdo(0, `ICS_IDX_DIR, 8'h01, 8'h00, 9'h100);
    sdo(0, `ICS_IDX_POL, 8'h01, 8'h02, 9'h100);
    sdo(1, `ICS_IDX_DIR, 8'h01, 8'h00, 9'h001);
    sdo(0, `ICS_IDX_DLY, 8'h10, 8'hff, 9'h000);
    sdo(1, `ICS_IDX_DLY, 8'h10, 8'h00, 9'h0ff);
    sdo(1, `ICS_IDX_DLY, 8'h0f, 8'h00, 9'h050);
    $display("test registers done");
  endtask
  task automatic t_surv();
    int n;
    sdo(0, `ICS_IDX_DLY, 8'h01, 8'h02, 9'h000);
    out_cmd[0] = 1'b1;
    out_cmd[2] = 1'b1;
    cyc(2);
    chk("monitor after edge", 16'h0000, mon & 16'h0005);
    wait_mon(40, n);
    chk("delay window", 16'h0001, {15'h0000, n >= TICK - 1 && n <= 2 * TICK + 1});
    chk("other channel", 16'h0000, mon & 16'h0004);
    $display("test surveillance done");
  endtask
  task automatic t_fault();
    chk("drive on", 16'h0001, drive & 16'h0001);
    fault[0] = 1'b1;
    cyc(2);
    chk("drive shut", 16'h0000, drive & 16'h0001);
    fault[0] = 1'b0;
    cyc(3);
    chk("drive held off", 16'h0000, drive & 16'h0001);
    sdo(0, `ICS_IDX_GEN, 8'h07, 8'h01, 9'h000);
    cyc(3);
    chk("drive restarted", 16'h0001, drive & 16'h0001);
    $display("test fault done");
  endtask
  task automatic em(input logic [1:0] c, input logic x);
    logic seen;
    seen = 1'b0;
    emcy_cls = c;
    emcy_req = 1'b1;
    cyc(1);
    emcy_req = 1'b0;
    repeat (3) begin
      seen = seen | emcy_send;
      cyc(1);
    end
    chk("emergency", {15'h0000, x}, {15'h0000, seen});
  endtask
  task automatic t_emcy();
    em(2'h0, 1'b1);
    sdo(0, `ICS_IDX_GEN, 8'h04, 8'h01, 9'h000);
    em(2'h1, 1'b0);
    em(2'h2, 1'b1);
    sdo(0, `ICS_IDX_GEN, 8'h05, 8'h01, 9'h000);
    em(2'h2, 1'b0);
    sdo(0, `ICS_IDX_GEN, 8'h03, 8'h01, 9'h000);
    em(2'h0, 1'b0);
    em(2'h2, 1'b0);
    $display("test emergency done");
  endtask
  task automatic t_din();
    di_mode[0] = 1'b1;
    sdo(0, `ICS_IDX_POL, 8'h01, 8'h01, 9'h000);
    cyc(3);
    chk("closed contact open", 16'h0001, di & 16'h0001);
    pin[0] = 1'b1;
    cyc(3);
    chk("closed contact shut", 16'h0000, di & 16'h0001);
    di_mode[0] = 1'b0;
    cyc(3);
    chk("polarity ignored", 16'h0001, di & 16'h0001);
    di_mode[0] = 1'b1;
    sdo(0, `ICS_IDX_FILT, 8'h01, 8'h03, 9'h000);
    pin[0] = 1'b0;
    cyc(3);
    chk("filter holds", 16'h0000, di & 16'h0001);
    cyc(14);
    chk("filter passes", 16'h0001, di & 16'h0001);
    $display("test input done");
  endtask
  task automatic t_gen();
    sdo(0, `ICS_IDX_GEN, 8'h01, 8'h01, 9'h000);
    sdo(0, `ICS_IDX_GEN, 8'h02, 8'h01, 9'h000);
    sdo(0, `ICS_IDX_GEN, 8'h06, 8'h01, 9'h000);
    sdo(0, `ICS_IDX_DIR, 8'h01, 8'h02, 9'h000);
    cyc(2);
    chk("general bits", 16'h0007, {13'h0000, web, frc, ext});
    chk("channel b out", 16'h0001, {8'h00, chb});
    $display("test general done");
  endtask
  task automatic t_ce();
    ce = 1'b0;
    out_cmd[0] = 1'b0;
    cyc(3);
    chk("drive frozen", 16'h0001, drive & 16'h0001);
    ce = 1'b1;
    cyc(2);
    chk("drive released", 16'h0000, drive & 16'h0001);
    chk("monitor after fall", 16'h0000, mon & 16'h0001);
    $display("test clock enable done");
  endtask
  task automatic t_rst();
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    sdo(1, `ICS_IDX_DLY, 8'h10, 8'h00, 9'h050);
    chk("monitor after reset", 16'h0000, mon);
    chk("general after reset", 16'h0000, {13'h0000, web, frc, ext});
    $display("test reset done");
  endtask
  initial begin
    cyc(20);
    reset = 1'b0;
    t_static();
    t_regs();
    t_surv();
    t_fault();
    t_emcy();
    t_din();
    t_gen();
    t_ce();
    t_rst();
    print_verdict();
  end
endmodule // ics_top_bench
`default_nettype wire
